// [design/lss_limit_switch_stop_handler.sv]
/*
  Limit switch stop handler: watches two end-of-travel switches and two soft limits,
  raises status and sticky events, in mode 0 stops the ramp hard or linearly and locks the
  blocked direction, and latches the position on chosen switch edges.
  Assumes a ramp generator that supplies target velocity, position and target, and
  a register port master with one-cycle strobes and read data one cycle later.
*/
`timescale 1ns/1ps
module lss_limit_switch_stop_handler (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWriteData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regReadData,
  output logic             irq,
  input  wire logic        leftLimitInput,
  input  wire logic        rightLimitInput,
  input  wire logic [31:0] rampVelocity,
  input  wire logic        rampStep,
  input  wire logic [31:0] currentPosition,
  input  wire logic [31:0] targetPosition,
  output logic      [31:0] currentVelocity,
  output logic             atTarget
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] limitConfig;
  logic [31:0] homeWindow;
  logic [31:0] stopDecel;
  logic [31:0] comparePos;
  logic [31:0] softLow;
  logic [31:0] softHigh;
  logic [31:0] homePos;
  logic [31:0] snapshot;
  localparam int EV_W = lss_pkg::EV_WIDTH;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] irqMask;
  logic [1:0]  mode;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisation and side mapping
  // ---------------------------------------------------------------
  logic [1:0] pinSync;
  logic [1:0] pinPrev;

  lss_sync #(
    .WIDTH(2)
  ) inSync (
    .clock   (clock),
    .rst     (rst),
    .asyncIn ({rightLimitInput, leftLimitInput}),
    .syncOut (pinSync)
  );

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pinPrev <= 2'h0;
    else
      pinPrev <= pinSync;
  end

  logic swap;
  logic leftLevel;
  logic rightLevel;
  logic leftPrevLevel;
  logic rightPrevLevel;
  logic leftActive;
  logic rightActive;
  assign swap           = limitConfig[lss_pkg::CFG_SWAP];
  assign leftLevel      = swap ? pinSync[1] : pinSync[0];
  assign rightLevel     = swap ? pinSync[0] : pinSync[1];
  assign leftPrevLevel  = swap ? pinPrev[1] : pinPrev[0];
  assign rightPrevLevel = swap ? pinPrev[0] : pinPrev[1];
  assign leftActive  = limitConfig[lss_pkg::CFG_LEFT_EN] &&
                       (leftLevel == limitConfig[lss_pkg::CFG_LEFT_POL]);
  assign rightActive = limitConfig[lss_pkg::CFG_RIGHT_EN] &&
                       (rightLevel == limitConfig[lss_pkg::CFG_RIGHT_POL]);

  // ---------------------------------------------------------------
  // Soft limits and target
  // ---------------------------------------------------------------
  logic softLowHit;
  logic softHighHit;
  assign softLowHit  = limitConfig[lss_pkg::CFG_SOFT_LOW_EN] &&
                       ($signed(currentPosition) <= $signed(softLow));
  assign softHighHit = limitConfig[lss_pkg::CFG_SOFT_HIGH_EN] &&
                       ($signed(currentPosition) >= $signed(softHigh));

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      atTarget <= 1'b0;
    else
      atTarget <= (currentPosition == targetPosition);
  end

  // ---------------------------------------------------------------
  // Stop decision
  // ---------------------------------------------------------------
  logic openLoop;
  logic velNeg;
  logic velPos;
  logic stopLeftCond;
  logic stopRightCond;
  logic anyStop;
  logic lockNeg;
  logic lockPos;
  assign openLoop = (mode == lss_pkg::MODE_RESET);
  assign velNeg   = currentVelocity[31];
  assign velPos   = !currentVelocity[31] && (currentVelocity != lss_pkg::WORD_ZERO);
  assign stopLeftCond  = (leftActive || softLowHit) && velNeg;
  assign stopRightCond = (rightActive || softHighHit) && velPos;
  assign anyStop = openLoop && (stopLeftCond || stopRightCond);

  // In mode 0, directions stay locked while the matching event remains set.
  assign lockNeg = openLoop && (events[lss_pkg::EV_STOP_LEFT] || events[lss_pkg::EV_SOFT_LOW]);
  assign lockPos = openLoop && (events[lss_pkg::EV_STOP_RIGHT] || events[lss_pkg::EV_SOFT_HIGH]);

  lss_pkg::lss_stop_type stopState;
  logic [31:0] next_velocity;
  logic [31:0] magnitude;
  logic [31:0] reduced;
  assign magnitude = velNeg ? (32'h0000_0000 - currentVelocity) : currentVelocity;
  assign reduced   = (magnitude > stopDecel) ? (magnitude - stopDecel) : lss_pkg::WORD_ZERO;

  always_comb
  begin
    next_velocity = rampVelocity;
    if (anyStop || stopState == lss_pkg::LSS_LINEAR)
      next_velocity = velNeg ? (32'h0000_0000 - reduced) : reduced;
    if (anyStop && !limitConfig[lss_pkg::CFG_LINEAR_STOP])
      next_velocity = lss_pkg::WORD_ZERO;
    if (lockNeg && next_velocity[31] && stopState == lss_pkg::LSS_RUN && !anyStop)
      next_velocity = lss_pkg::WORD_ZERO;
    if (lockPos && !next_velocity[31] && stopState == lss_pkg::LSS_RUN && !anyStop)
      next_velocity = lss_pkg::WORD_ZERO;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      stopState <= lss_pkg::LSS_RUN;
    else
    begin
      case (stopState)
        lss_pkg::LSS_RUN:
          if (anyStop && limitConfig[lss_pkg::CFG_LINEAR_STOP] && rampStep)
            stopState <= lss_pkg::LSS_LINEAR;
        lss_pkg::LSS_LINEAR:
          if (!openLoop || (rampStep && next_velocity == lss_pkg::WORD_ZERO))
            stopState <= lss_pkg::LSS_RUN;
        default:
          stopState <= lss_pkg::LSS_RUN;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      currentVelocity <= lss_pkg::WORD_ZERO;
    else if (!openLoop)
      currentVelocity <= rampVelocity;
    else if (anyStop && !limitConfig[lss_pkg::CFG_LINEAR_STOP])
      currentVelocity <= lss_pkg::WORD_ZERO;
    else if (rampStep)
      currentVelocity <= next_velocity;
  end

  // ---------------------------------------------------------------
  // Position snapshot edges
  // ---------------------------------------------------------------
  logic leftPress;
  logic leftRelease;
  logic rightPress;
  logic rightRelease;
  logic latchNow;
  assign leftPress    = (leftLevel != leftPrevLevel) && (leftLevel == limitConfig[lss_pkg::CFG_LEFT_POL]);
  assign leftRelease  = (leftLevel != leftPrevLevel) && (leftLevel != limitConfig[lss_pkg::CFG_LEFT_POL]);
  assign rightPress   = (rightLevel != rightPrevLevel) && (rightLevel == limitConfig[lss_pkg::CFG_RIGHT_POL]);
  assign rightRelease = (rightLevel != rightPrevLevel) && (rightLevel != limitConfig[lss_pkg::CFG_RIGHT_POL]);
  assign latchNow = (leftPress && limitConfig[lss_pkg::CFG_LATCH_PRESS_L]) ||
                    (leftRelease && limitConfig[lss_pkg::CFG_LATCH_REL_L]) ||
                    (rightPress && limitConfig[lss_pkg::CFG_LATCH_PRESS_R]) ||
                    (rightRelease && limitConfig[lss_pkg::CFG_LATCH_REL_R]);

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      limitConfig <= lss_pkg::LIMIT_CONFIG_RESET;
      homeWindow  <= lss_pkg::WORD_ZERO;
      stopDecel   <= lss_pkg::WORD_ZERO;
      comparePos  <= lss_pkg::WORD_ZERO;
      softLow     <= lss_pkg::WORD_ZERO;
      softHigh    <= lss_pkg::WORD_ZERO;
      homePos     <= lss_pkg::WORD_ZERO;
      irqMask     <= '0;
      mode        <= lss_pkg::MODE_RESET;
    end
    else if (regWrite)
    begin
      if (hit(regAddr, lss_pkg::REG_LIMIT_CONFIG))
        limitConfig <= regWriteData;
      if (hit(regAddr, lss_pkg::REG_HOME_WINDOW))
        homeWindow <= regWriteData;
      if (hit(regAddr, lss_pkg::REG_STOP_DECEL))
        stopDecel <= regWriteData;
      if (hit(regAddr, lss_pkg::REG_COMPARE_POS))
        comparePos <= regWriteData;
      if (hit(regAddr, lss_pkg::REG_SOFT_LOW))
        softLow <= regWriteData;
      if (hit(regAddr, lss_pkg::REG_SOFT_HIGH))
        softHigh <= regWriteData;
      if (hit(regAddr, lss_pkg::REG_HOME_POS))
        homePos <= regWriteData;
      if (hit(regAddr, lss_pkg::REG_IRQ_MASK))
        irqMask <= regWriteData[EV_W-1:0];
      if (hit(regAddr, lss_pkg::REG_MODE))
        mode <= regWriteData[1:0];
    end
  end

  // Snapshot takes the switch edge in preference to a software write.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      snapshot <= lss_pkg::WORD_ZERO;
    else if (latchNow)
      snapshot <= currentPosition;
    else if (regWrite && hit(regAddr, lss_pkg::REG_SNAPSHOT))
      snapshot <= regWriteData;
  end

  // ---------------------------------------------------------------
  // Events: set wins over clear
  // ---------------------------------------------------------------
  logic [EV_W-1:0] eventSet;
  logic [EV_W-1:0] eventClear;
  assign eventSet = {latchNow, softHighHit, softLowHit, rightActive, leftActive};
  always_comb
  begin
    eventClear = '0;
    if (regRead && hit(regAddr, lss_pkg::REG_EVENTS))
      eventClear = '1;
    if (regWrite && hit(regAddr, lss_pkg::REG_EVENTS))
      eventClear = regWriteData[EV_W-1:0];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      events <= '0;
    else
      events <= (events & ~eventClear) | eventSet;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(events & irqMask);
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [31:0] statusWord;
  always_comb
  begin
    statusWord = lss_pkg::WORD_ZERO;
    statusWord[lss_pkg::ST_LEFT_ACTIVE]  = leftActive;
    statusWord[lss_pkg::ST_RIGHT_ACTIVE] = rightActive;
    statusWord[lss_pkg::ST_LEFT_LEVEL]   = leftLevel;
    statusWord[lss_pkg::ST_RIGHT_LEVEL]  = rightLevel;
    statusWord[lss_pkg::ST_AT_TARGET]    = atTarget;
    statusWord[lss_pkg::ST_SOFT_LOW]     = softLowHit;
    statusWord[lss_pkg::ST_SOFT_HIGH]    = softHighHit;
    statusWord[lss_pkg::ST_STOPPING]     = (stopState == lss_pkg::LSS_LINEAR);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      regReadData <= lss_pkg::WORD_ZERO;
    else if (regRead)
    begin
      case (regAddr)
        lss_pkg::REG_LIMIT_CONFIG: regReadData <= limitConfig;
        lss_pkg::REG_EVENTS:       regReadData <= {{(32-EV_W){1'b0}}, events};
        lss_pkg::REG_STATUS:       regReadData <= statusWord;
        lss_pkg::REG_HOME_WINDOW:  regReadData <= homeWindow;
        lss_pkg::REG_STOP_DECEL:   regReadData <= stopDecel;
        lss_pkg::REG_COMPARE_POS:  regReadData <= comparePos;
        lss_pkg::REG_SOFT_LOW:     regReadData <= softLow;
        lss_pkg::REG_SOFT_HIGH:    regReadData <= softHigh;
        lss_pkg::REG_HOME_POS:     regReadData <= homePos;
        lss_pkg::REG_SNAPSHOT:     regReadData <= snapshot;
        lss_pkg::REG_IRQ_MASK:     regReadData <= {{(32-EV_W){1'b0}}, irqMask};
        lss_pkg::REG_MODE:         regReadData <= {30'h0000_0000, mode};
        default:                   regReadData <= lss_pkg::WORD_ZERO;
      endcase
    end
  end
endmodule

// [design/lss_pkg.sv]
/*
  Constants for the limit switch stop handler: register indices, field positions,
  reset values and event/status layouts.
  Assumes a register port with word indices; byte address is not used.
*/
package lss_pkg;
  localparam logic [7:0] REG_LIMIT_CONFIG  = 8'h01;
  localparam logic [7:0] REG_EVENTS        = 8'h0E;
  localparam logic [7:0] REG_STATUS        = 8'h0F;
  localparam logic [7:0] REG_HOME_WINDOW   = 8'h1E;
  localparam logic [7:0] REG_STOP_DECEL    = 8'h2C;
  localparam logic [7:0] REG_COMPARE_POS   = 8'h32;
  localparam logic [7:0] REG_SOFT_LOW      = 8'h33;
  localparam logic [7:0] REG_SOFT_HIGH     = 8'h34;
  localparam logic [7:0] REG_HOME_POS      = 8'h35;
  localparam logic [7:0] REG_SNAPSHOT      = 8'h36;
  localparam logic [7:0] REG_IRQ_MASK      = 8'h40;
  localparam logic [7:0] REG_MODE          = 8'h41;

  localparam int CFG_LEFT_EN        = 0;
  localparam int CFG_RIGHT_EN       = 1;
  localparam int CFG_LEFT_POL       = 2;
  localparam int CFG_RIGHT_POL      = 3;
  localparam int CFG_SWAP           = 4;
  localparam int CFG_LINEAR_STOP    = 5;
  localparam int CFG_LATCH_REL_L    = 6;
  localparam int CFG_LATCH_PRESS_L  = 7;
  localparam int CFG_LATCH_REL_R    = 8;
  localparam int CFG_LATCH_PRESS_R  = 9;
  localparam int CFG_SOFT_LOW_EN    = 10;
  localparam int CFG_SOFT_HIGH_EN   = 11;

  localparam int EV_STOP_LEFT   = 0;
  localparam int EV_STOP_RIGHT  = 1;
  localparam int EV_SOFT_LOW    = 2;
  localparam int EV_SOFT_HIGH   = 3;
  localparam int EV_LATCHED     = 4;
  localparam int EV_WIDTH       = 5;

  localparam int ST_LEFT_ACTIVE   = 0;
  localparam int ST_RIGHT_ACTIVE  = 1;
  localparam int ST_LEFT_LEVEL    = 2;
  localparam int ST_RIGHT_LEVEL   = 3;
  localparam int ST_AT_TARGET     = 4;
  localparam int ST_SOFT_LOW      = 5;
  localparam int ST_SOFT_HIGH     = 6;
  localparam int ST_STOPPING      = 7;

  localparam logic [31:0] LIMIT_CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO          = 32'h0000_0000;
  localparam logic [1:0]  MODE_RESET         = 2'h0;

  typedef enum logic [1:0] {
    LSS_RUN    = 2'b00,
    LSS_LINEAR = 2'b01
  } lss_stop_type;
endpackage

// [design/lss_sync.sv]
/*
  Two-flop synchroniser for a bundle of asynchronous levels.
  Assumes the inputs come from pins outside the clock domain.
*/
`timescale 1ns/1ps
module lss_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stage1  <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule

// [test/lss_checker_asserts.sv]
/*
  Port checker for the limit switch stop handler.
  Assumes one clock, rst asynchronous active high, and register writes seen on the port.
*/
`timescale 1ns/1ps
module lss_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWriteData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regReadData,
  input wire logic        irq,
  input wire logic        leftLimitInput,
  input wire logic        rightLimitInput,
  input wire logic        rampStep,
  input wire logic [31:0] currentPosition,
  input wire logic [31:0] targetPosition,
  input wire logic [31:0] currentVelocity,
  input wire logic        atTarget
);
  logic [31:0] cfg;
  logic [31:0] mask;
  logic [1:0]  mode;
  logic [2:0]  cntL;
  logic [2:0]  cntR;
  logic        hard;
  logic        linear;
  logic [1:0]  pins;

  // ---------------------------------------------------------------
  // Shadow copies of configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cfg  <= 32'h0000_0000;
      mask <= 32'h0000_0000;
      mode <= 2'h0;
    end
    else if (regWrite)
    begin
      if (regAddr == lss_pkg::REG_LIMIT_CONFIG)
        cfg <= regWriteData;
      if (regAddr == lss_pkg::REG_IRQ_MASK)
        mask <= regWriteData;
      if (regAddr == lss_pkg::REG_MODE)
        mode <= regWriteData[1:0];
    end
  end

  assign hard   = !cfg[lss_pkg::CFG_LINEAR_STOP] && mode == 2'h0;
  assign pins   = cfg[lss_pkg::CFG_SWAP] ? {leftLimitInput, rightLimitInput} : {rightLimitInput, leftLimitInput};
  assign linear = cfg[lss_pkg::CFG_LINEAR_STOP] && mode == 2'h0;

  // Cycles for which each enabled switch has stood at its active level while hard stop is set in mode 0.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cntL <= 3'h0;
    else if (!(hard && cfg[lss_pkg::CFG_LEFT_EN] && pins[0] == cfg[lss_pkg::CFG_LEFT_POL]))
      cntL <= 3'h0;
    else if (cntL != 3'h7)
      cntL <= cntL + 3'h1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cntR <= 3'h0;
    else if (!(hard && cfg[lss_pkg::CFG_RIGHT_EN] && pins[1] == cfg[lss_pkg::CFG_RIGHT_POL]))
      cntR <= 3'h0;
    else if (cntR != 3'h7)
      cntR <= cntR + 3'h1;
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  at_target_a: assert property (!$past(rst) |-> atTarget == $past(currentPosition == targetPosition))
    else $error("at-target output does not follow position compare");
  unmapped_zero_a: assert property (regRead && !(regAddr inside {8'h01, 8'h0E, 8'h0F, 8'h1E, 8'h2C, 8'h32,
    8'h33, 8'h34, 8'h35, 8'h36, 8'h40, 8'h41}) |=> regReadData == 32'h0000_0000)
    else $error("unmapped read not zero");
  config_readback_a: assert property (regRead && regAddr == lss_pkg::REG_LIMIT_CONFIG |=> regReadData[11:0] == cfg[11:0])
    else $error("limit config readback wrong");
  irq_masked_a: assert property (mask == 32'h0000_0000 && $past(mask) == 32'h0000_0000 |-> !irq)
    else $error("interrupt with everything masked");
  left_stop_a: assert property (cntL >= 3'h5 |-> !currentVelocity[31])
    else $error("negative velocity while left limit active");
  right_stop_a: assert property (cntR >= 3'h5 |-> $signed(currentVelocity) <= 0)
    else $error("positive velocity while right limit active");
  input_sync_a: assert property (hard && cfg[lss_pkg::CFG_LEFT_EN] && cfg[lss_pkg::CFG_LEFT_POL] && $rose(leftLimitInput)
    && !rampStep && currentVelocity[31] |=> $stable(currentVelocity))
    else $error("switch acted before synchronisation");
  linear_step_a: assert property (linear && !rampStep |=> $stable(currentVelocity))
    else $error("linear stop moved velocity off a ramp tick");

  cover property (cntL == 3'h5);
  cover property (linear && rampStep && currentVelocity != 32'h0000_0000);
  cover property ($rose(irq));
endmodule

bind lss_limit_switch_stop_handler lss_checker u_chk (.clock(clock), .rst(rst), .regAddr(regAddr),
  .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .irq(irq),
  .leftLimitInput(leftLimitInput), .rightLimitInput(rightLimitInput), .rampStep(rampStep),
  .currentPosition(currentPosition), .targetPosition(targetPosition), .currentVelocity(currentVelocity),
  .atTarget(atTarget));

// [test/lss_switch_model.sv]
/*
  Two mechanical end-of-travel switches.
  Assumes the bench says which switch is pressed and at which level each is wired.
*/
`timescale 1ns/1ps
module lss_switch_model (
  input  wire logic pressLeft,
  input  wire logic pressRight,
  input  wire logic polLeft,
  input  wire logic polRight,
  output logic      leftPin,
  output logic      rightPin
);
  // A pressed switch shows its active level and a free one the opposite level.
  assign leftPin  = pressLeft ? polLeft : ~polLeft;
  assign rightPin = pressRight ? polRight : ~polRight;
endmodule

// [test/lss_testbench.sv]
/*
  Self-checking bench for the limit switch stop handler.
  Assumes the switch model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module testbench;
  logic        clock;
  logic        rst;
  logic [7:0]  regAddr;
  logic [31:0] regWriteData;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regReadData;
  logic        irq;
  logic        leftPin;
  logic        rightPin;
  logic [31:0] rampVelocity;
  logic        rampStep;
  logic [31:0] currentPosition;
  logic [31:0] targetPosition;
  logic [31:0] currentVelocity;
  logic        atTarget;
  logic        pressL;
  logic        pressR;
  logic        polL;
  logic        polR;
  int          miscompares;
  int          nCompared;
  logic [31:0] d;

  lss_limit_switch_stop_handler dut (.clock(clock), .rst(rst), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .irq(irq), .leftLimitInput(leftPin),
    .rightLimitInput(rightPin), .rampVelocity(rampVelocity), .rampStep(rampStep), .currentPosition(currentPosition),
    .targetPosition(targetPosition), .currentVelocity(currentVelocity), .atTarget(atTarget));
  lss_switch_model sw (.pressLeft(pressL), .pressRight(pressR), .polLeft(polL), .polRight(polR),
    .leftPin(leftPin), .rightPin(rightPin));

  always #4 clock = ~clock;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic chkb(input string name, input logic seen, input logic exp);
    chk(name, {31'h0000_0000, seen}, {31'h0000_0000, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    regWrite     <= 1'b1;
    regAddr      <= a;
    regWriteData <= v;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    v = regReadData;
  endtask
  task automatic step(input logic [31:0] v);
    @(posedge clock);
    rampStep     <= 1'b1;
    rampVelocity <= v;
    @(posedge clock);
    rampStep <= 1'b0;
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic drive(input logic l, input logic r, input logic pl, input logic pr, input logic [31:0] pos);
    @(posedge clock);
    pressL          <= l;
    pressR          <= r;
    polL            <= pl;
    polR            <= pr;
    currentPosition <= pos;
  endtask
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk("velocity", currentVelocity, 32'h0000_0000);
    rd(lss_pkg::REG_LIMIT_CONFIG, d);
    chk("limit_config", d, lss_pkg::LIMIT_CONFIG_RESET);
    wr(8'h7F, 32'hFFFF_FFFF);
    rd(8'h7F, d);
    chk("unmapped", d, 32'h0000_0000);
    wr(lss_pkg::REG_STOP_DECEL, 32'h0000_001E);
    rd(lss_pkg::REG_STOP_DECEL, d);
    chk("stop_deceleration", d, 32'h0000_001E);
  endtask
  task automatic t_left_hard();
    wr(lss_pkg::REG_IRQ_MASK, 32'h0000_0001);
    wr(lss_pkg::REG_LIMIT_CONFIG, 32'h0000_000F);
    step(32'hFFFF_FF9C);
    chk("velocity", currentVelocity, 32'hFFFF_FF9C);
    drive(1'b1, 1'b0, 1'b1, 1'b1, 32'h0000_0000);
    idle(6);
    chk("velocity", currentVelocity, 32'h0000_0000);
    chkb("irq", irq, 1'b1);
    rd(lss_pkg::REG_STATUS, d);
    chkb("left active", d[lss_pkg::ST_LEFT_ACTIVE], 1'b1);
    chkb("left level", d[lss_pkg::ST_LEFT_LEVEL], 1'b1);
    drive(1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_0000);
    idle(4);
    rd(lss_pkg::REG_STATUS, d);
    chkb("left active", d[lss_pkg::ST_LEFT_ACTIVE], 1'b0);
    step(32'hFFFF_FF9C);
    chk("velocity", currentVelocity, 32'h0000_0000);
    rd(lss_pkg::REG_EVENTS, d);
    chkb("left event", d[lss_pkg::EV_STOP_LEFT], 1'b1);
    rd(lss_pkg::REG_EVENTS, d);
    chkb("left event", d[lss_pkg::EV_STOP_LEFT], 1'b0);
    chkb("irq", irq, 1'b0);
    step(32'hFFFF_FF9C);
    chk("velocity", currentVelocity, 32'hFFFF_FF9C);
  endtask
  task automatic t_right_linear();
    wr(lss_pkg::REG_LIMIT_CONFIG, 32'h0000_002F);
    step(32'h0000_0064);
    drive(1'b0, 1'b1, 1'b1, 1'b1, 32'h0000_0000);
    idle(6);
    chk("velocity", currentVelocity, 32'h0000_0064);
    step(32'h0000_0064);
    chk("velocity", currentVelocity, 32'h0000_0046);
    step(32'h0000_0064);
    chk("velocity", currentVelocity, 32'h0000_0028);
    step(32'h0000_0064);
    chk("velocity", currentVelocity, 32'h0000_000A);
    step(32'h0000_0064);
    chk("velocity", currentVelocity, 32'h0000_0000);
    chkb("irq", irq, 1'b0);
    rd(lss_pkg::REG_EVENTS, d);
    chkb("right event", d[lss_pkg::EV_STOP_RIGHT], 1'b1);
    drive(1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_0000);
    idle(4);
    rd(lss_pkg::REG_EVENTS, d);
    step(32'h0000_0064);
    chk("velocity", currentVelocity, 32'h0000_0064);
  endtask
  task automatic t_mode_ext();
    wr(lss_pkg::REG_LIMIT_CONFIG, 32'h0000_000F);
    wr(lss_pkg::REG_MODE, 32'h0000_0001);
    drive(1'b1, 1'b0, 1'b1, 1'b1, 32'h0000_0000);
    idle(6);
    step(32'hFFFF_FFCE);
    idle(2);
    chk("velocity", currentVelocity, 32'hFFFF_FFCE);
    rd(lss_pkg::REG_STATUS, d);
    chkb("left level", d[lss_pkg::ST_LEFT_LEVEL], 1'b1);
    drive(1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_0000);
    wr(lss_pkg::REG_MODE, 32'h0000_0000);
    idle(4);
    rd(lss_pkg::REG_EVENTS, d);
  endtask
  task automatic t_swap();
    wr(lss_pkg::REG_LIMIT_CONFIG, 32'h0000_0018);
    drive(1'b0, 1'b0, 1'b1, 1'b0, 32'h0000_0000);
    idle(4);
    wr(lss_pkg::REG_LIMIT_CONFIG, 32'h0000_001B);
    step(32'h0000_0064);
    drive(1'b1, 1'b0, 1'b1, 1'b0, 32'h0000_0000);
    idle(6);
    chk("velocity", currentVelocity, 32'h0000_0000);
    rd(lss_pkg::REG_STATUS, d);
    chkb("right active", d[lss_pkg::ST_RIGHT_ACTIVE], 1'b1);
    drive(1'b0, 1'b0, 1'b1, 1'b0, 32'h0000_0000);
    wr(lss_pkg::REG_LIMIT_CONFIG, 32'h0000_000C);
    drive(1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_0000);
    idle(4);
    rd(lss_pkg::REG_EVENTS, d);
    chkb("right event", d[lss_pkg::EV_STOP_RIGHT], 1'b1);
  endtask
  task automatic t_latch();
    wr(lss_pkg::REG_LIMIT_CONFIG, 32'h0000_0008);
    drive(1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_1234);
    idle(4);
    wr(lss_pkg::REG_LIMIT_CONFIG, 32'h0000_0188);
    drive(1'b1, 1'b0, 1'b0, 1'b1, 32'h0000_1234);
    idle(5);
    rd(lss_pkg::REG_SNAPSHOT, d);
    chk("snapshot", d, 32'h0000_1234);
    drive(1'b0, 1'b1, 1'b0, 1'b1, 32'h0000_0055);
    idle(5);
    rd(lss_pkg::REG_SNAPSHOT, d);
    chk("snapshot", d, 32'h0000_1234);
    drive(1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_0055);
    idle(5);
    rd(lss_pkg::REG_SNAPSHOT, d);
    chk("snapshot", d, 32'h0000_0055);
    wr(lss_pkg::REG_LIMIT_CONFIG, 32'h0000_000C);
    drive(1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_0055);
    idle(4);
    rd(lss_pkg::REG_EVENTS, d);
  endtask
  task automatic t_soft();
    wr(lss_pkg::REG_SOFT_LOW, 32'hFFFF_FF00);
    wr(lss_pkg::REG_LIMIT_CONFIG, 32'h0000_040F);
    drive(1'b0, 1'b0, 1'b1, 1'b1, 32'hFFFF_FF01);
    targetPosition <= 32'hFFFF_FF01;
    idle(3);
    chkb("at target", atTarget, 1'b1);
    rd(lss_pkg::REG_EVENTS, d);
    chkb("soft low event", d[lss_pkg::EV_SOFT_LOW], 1'b0);
    drive(1'b0, 1'b0, 1'b1, 1'b1, 32'hFFFF_FF00);
    idle(3);
    chkb("at target", atTarget, 1'b0);
    rd(lss_pkg::REG_EVENTS, d);
    chkb("soft low event", d[lss_pkg::EV_SOFT_LOW], 1'b1);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    clock           = 1'b0;
    rst             = 1'b1;
    regAddr         = 8'h00;
    regWriteData    = 32'h0000_0000;
    regWrite        = 1'b0;
    regRead         = 1'b0;
    rampVelocity    = 32'h0000_0000;
    rampStep        = 1'b0;
    currentPosition = 32'h0000_0000;
    targetPosition  = 32'h0000_0000;
    pressL          = 1'b0;
    pressR          = 1'b0;
    polL            = 1'b1;
    polR            = 1'b1;
    miscompares     = 0;
    nCompared       = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    idle(1);
    t_reset();
    t_left_hard();
    t_right_linear();
    t_mode_ext();
    t_swap();
    t_latch();
    t_soft();
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    print_verdict();
  end
endmodule
